//--- core/asb_pkg.sv
// Shared constants and types for the setup-byte serial link, both ends
package asb_pkg;
  // ****************************************************************
  // Functional notes
  // ****************************************************************
  // Functional notes
  // - Top bit one is setup, zero config
  // - Bits six to four pick reference, reset 000
  // - Clock bit one selects bus conversion clock
  // - Polarity bit picks bipolar, resets to unipolar
  // - Single-ended result is channel against ground
  // - Differential result is plus minus minus
  // - Unipolar negative difference clamps to zero
  // - Unipolar straight binary, bipolar twos complement
  // - Single-ended always converts unipolar
  // - One bit per clock, nine per byte
  // - Data stable while clock high, else control
  // - Master starts transfers and drives clock
  // - Idle bus lines are released high

  // ****************************************************************
  // Byte layouts
  // ****************************************************************
  localparam int SB_KIND_BIT  = 7;
  localparam int SB_REF_HI    = 6;
  localparam int SB_REF_LO    = 4;
  localparam int SB_CLK_BIT   = 3;
  localparam int SB_POL_BIT   = 2;
  localparam int SB_CRST_BIT  = 1;
  localparam int SB_SHARE_BIT = 1;   // Within the reference field
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_CS_HI    = 4;
  localparam int CFG_CS_LO    = 1;

  // ****************************************************************
  // Reset values and code limits
  // ****************************************************************
  localparam logic [2:0] REF_RESET = 3'h0;
  localparam logic       CLK_RESET = 1'h0;
  localparam logic       POL_RESET = 1'h0;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [7:0] UNI_ZERO  = 8'h00;
  localparam logic [7:0] BIP_MAX   = 8'h7F;
  localparam logic [7:0] BIP_MIN   = 8'h80;

  // ****************************************************************
  // Framing and addressing
  // ****************************************************************
  localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
  localparam logic [3:0] ACK_SLOT         = 4'h8;
  localparam logic       WR_DIR           = 1'h0;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h64;

  // ****************************************************************
  // Host registers and timing
  // ****************************************************************
  localparam logic [7:0] REG_TX     = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int ST_BUSY  = 0;
  localparam int ST_ANACK = 1;
  localparam int ST_DNACK = 2;
  localparam int CORE_CLK_NS     = 25;
  localparam int SCL_QUARTER_NS  = 625;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} asb_host_st_t;
endpackage

//--- core/asb_link_if.sv
// Open-drain two-wire link joining the host end and the device end
interface asb_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: a line is low only while someone drives it low
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

//--- core/asb_device.sv
// Device end: setup-byte receiver on the link clock, result coding on the core clock
module asb_device
  import asb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  asb_link_if.slave       link,
  input  wire logic [7:0] ain_pos_code,
  input  wire logic [7:0] ain_neg_code,
  output logic      [2:0] ref_select,
  output logic            shared_input_ref_pin_ref,
  output logic            conv_clk_external,
  output logic            polarity_select,
  output logic            input_mode_select,
  output logic      [3:0] channel_select,
  output logic      [7:0] result_code,
  output logic            result_bipolar,
  output logic            setup_update
);

  // ****************************************************************
  // State types, one per clock edge
  // ****************************************************************
  typedef struct packed {
    logic start_tgl;
  } asb_sda_t;

  typedef struct packed {
    logic sda_at_rise;
  } asb_rise_t;

  typedef struct packed {
    logic       start_seen;
    logic       active;
    logic       in_addr;
    logic       ack_drive;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [2:0] ref_sel;
    logic       clk_ext;
    logic       pol;
    logic [7:0] cfg;
    logic       upd_tgl;
  } asb_link_t;

  typedef struct packed {
    logic       upd_s1;
    logic       upd_s2;
    logic       upd_s3;
    logic       update;
    logic [2:0] ref_sel;
    logic       clk_ext;
    logic       pol;
    logic [7:0] cfg;
    logic [7:0] result;
    logic       bip;
  } asb_core_t;

  asb_sda_t  sq;
  asb_sda_t  sn;
  asb_rise_t rq;
  asb_rise_t rn;
  asb_link_t lq;
  asb_link_t ln;
  asb_core_t cq;
  asb_core_t cn;
  logic [7:0] rx_byte;
  logic [8:0] diff;

  // ****************************************************************
  // Start detection on the data line
  // ****************************************************************
  // A fall of the data line while the clock is high opens a frame;
  // a toggle is kept so the link side sees it without a handshake
  always_comb begin
    sn = sq;
    if (link.scl) begin
      sn.start_tgl = !sq.start_tgl;
    end
  end

  // The link has no edges in reset, so these flops clear without it
  always_ff @(negedge link.sda or posedge reset) begin
    if (reset) begin
      sq <= '0;
    end else begin
      sq <= sn;
    end
  end

  // ****************************************************************
  // Bit capture on the rising link clock
  // ****************************************************************
  // Data is taken while the clock is high, where it must be stable
  always_comb begin
    rn = rq;
    rn.sda_at_rise = link.sda;
  end

  always_ff @(posedge link.scl or posedge reset) begin
    if (reset) begin
      rq <= '0;
    end else begin
      rq <= rn;
    end
  end

  // ****************************************************************
  // Byte framing and setup decode on the falling link clock
  // ****************************************************************
  // Each falling edge closes one bit; the ninth is the acknowledge slot
  always_comb begin
    ln      = lq;
    rx_byte = {lq.shift[6:0], rq.sda_at_rise};
    if (sq.start_tgl != lq.start_seen) begin
      // Control condition: restart framing whatever was in progress
      ln.start_seen = sq.start_tgl;
      ln.active     = 1'h1;
      ln.in_addr    = 1'h1;
      ln.ack_drive  = 1'h0;
      ln.bit_cnt    = 4'h0;
    end else if (lq.active) begin
      if (lq.bit_cnt == ACK_SLOT) begin
        // Release the line at the end of the acknowledge slot
        ln.ack_drive = 1'h0;
        ln.bit_cnt   = 4'h0;
        ln.in_addr   = 1'h0;
        ln.active    = lq.ack_drive;
      end else begin
        ln.shift   = rx_byte;
        ln.bit_cnt = lq.bit_cnt + 4'h1;
        if (lq.bit_cnt == LAST_DATA_BIT) begin
          if (lq.in_addr) begin
            // Only a write to our address is acknowledged
            ln.ack_drive = (rx_byte[7:1] == DEV_ADDR) && (rx_byte[0] == WR_DIR);
          end else begin
            ln.ack_drive = 1'h1;
            ln.upd_tgl   = !lq.upd_tgl;
            if (rx_byte[SB_KIND_BIT]) begin
              ln.ref_sel = rx_byte[SB_REF_HI:SB_REF_LO];
              ln.clk_ext = rx_byte[SB_CLK_BIT];
              ln.pol     = rx_byte[SB_POL_BIT];
              if (!rx_byte[SB_CRST_BIT]) begin
                ln.cfg = CFG_RESET;
              end
            end else begin
              ln.cfg = rx_byte;
            end
          end
        end
      end
    end
  end

  // Reset release happens while the link is idle, so no edge races it
  always_ff @(negedge link.scl or posedge reset) begin
    if (reset) begin
      lq            <= '0;
      lq.ref_sel    <= REF_RESET;
      lq.clk_ext    <= CLK_RESET;
      lq.pol        <= POL_RESET;
      lq.cfg        <= CFG_RESET;
    end else begin
      lq <= ln;
    end
  end

  // Open drain: only ever pull low, and only in the acknowledge slot
  assign link.s_sda_o  = 1'h0;
  assign link.s_sda_oe = lq.ack_drive;

  // ****************************************************************
  // Core side: crossing and result coding
  // ****************************************************************
  // The update toggle is synchronised; the setup words it flags change
  // on the same edge and then hold for a whole byte time, so they are taken as is
  always_comb begin
    cn        = cq;
    cn.upd_s1 = lq.upd_tgl;
    cn.upd_s2 = cq.upd_s1;
    cn.upd_s3 = cq.upd_s2;
    cn.update = cq.upd_s2 != cq.upd_s3;
    if (cq.upd_s2 != cq.upd_s3) begin
      cn.ref_sel = lq.ref_sel;
      cn.clk_ext = lq.clk_ext;
      cn.pol     = lq.pol;
      cn.cfg     = lq.cfg;
    end
    diff = {1'h0, ain_pos_code} - {1'h0, ain_neg_code};
    if (cq.cfg[CFG_MODE_BIT]) begin
      // Single-ended ignores polarity and measures against ground
      cn.result = ain_pos_code;
      cn.bip    = 1'h0;
    end else if (!cq.pol) begin
      // Unipolar straight binary, a borrow means a negative input
      cn.result = diff[8] ? UNI_ZERO : diff[7:0];
      cn.bip    = 1'h0;
    end else begin
      // Bipolar covers half the span each way, so saturate the ends
      cn.bip = 1'h1;
      if (!diff[8] && diff[7]) begin
        cn.result = BIP_MAX;
      end else if (diff[8] && !diff[7]) begin
        cn.result = BIP_MIN;
      end else begin
        cn.result = diff[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cq         <= '0;
      cq.ref_sel <= REF_RESET;
      cq.clk_ext <= CLK_RESET;
      cq.pol     <= POL_RESET;
      cq.cfg     <= CFG_RESET;
    end else begin
      cq <= cn;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ref_select               = cq.ref_sel;
  assign shared_input_ref_pin_ref = cq.ref_sel[SB_SHARE_BIT];
  assign conv_clk_external        = cq.clk_ext;
  assign polarity_select          = cq.pol;
  assign input_mode_select        = cq.cfg[CFG_MODE_BIT];
  assign channel_select           = cq.cfg[CFG_CS_HI:CFG_CS_LO];
  assign result_code              = cq.result;
  assign result_bipolar           = cq.bip;
  assign setup_update             = cq.update;

endmodule

//--- core/asb_host.sv
// Host end: register-driven bus master that writes one byte per transaction
module asb_host
  import asb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DEFAULT,
  parameter int         QUARTER_CYC = SCL_QUARTER_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  asb_link_if.master      link,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            busy
);

  localparam int QW = (QUARTER_CYC > 1) ? $clog2(QUARTER_CYC) : 1;

  typedef struct packed {
    asb_host_st_t st;
    logic [QW-1:0] qcnt;
    logic [1:0]    phase;
    logic [3:0]    bit_idx;
    logic          clearing;
    logic          data_byte;
    logic [7:0]    shift;
    logic [7:0]    tx_byte;
    logic [7:0]    rdata;
    logic          scl_oe;
    logic          sda_oe;
    logic          nack_addr;
    logic          nack_data;
    logic          busy;
    logic          sda_s1;
    logic          sda_s2;
  } asb_host_state_t;

  asb_host_state_t hq;
  asb_host_state_t hn;
  logic            tick;
  logic [7:0]      status_word;

  // ****************************************************************
  // Bus master sequencing
  // ****************************************************************
  // Each bit is four quarters: clock low, data set, clock high, sample.
  // Data moves a quarter after the fall so it never changes while high.
  always_comb begin
    hn        = hq;
    hn.sda_s1 = link.sda;
    hn.sda_s2 = hq.sda_s1;
    tick      = hq.qcnt == QW'(QUARTER_CYC - 1);
    hn.qcnt   = tick ? '0 : hq.qcnt + QW'(1);
    status_word           = 8'h00;
    status_word[ST_BUSY]  = hq.busy;
    status_word[ST_ANACK] = hq.nack_addr;
    status_word[ST_DNACK] = hq.nack_data;
    if (reg_rd) begin
      if (reg_addr == REG_TX) begin
        hn.rdata = hq.tx_byte;
      end else if (reg_addr == REG_STATUS) begin
        hn.rdata = status_word;
      end else begin
        hn.rdata = 8'h00;
      end
    end
    case (hq.st)
      H_IDLE: begin
        hn.qcnt  = '0;
        hn.phase = 2'h0;
        // Writes while busy are dropped; idle lines stay released
        if (reg_wr && (reg_addr == REG_TX)) begin
          hn.st        = H_START;
          hn.busy      = 1'h1;
          hn.tx_byte   = reg_wdata;
          hn.shift     = {DEV_ADDR, WR_DIR};
          hn.data_byte = 1'h0;
          hn.bit_idx   = 4'h0;
          hn.nack_addr = 1'h0;
          hn.nack_data = 1'h0;
        end
      end
      H_START: begin
        if (tick) begin
          hn.sda_oe = 1'h1;
          hn.st     = H_BIT;
        end
      end
      H_BIT: begin
        if (tick) begin
          hn.phase = hq.phase + 2'h1;
          case (hq.phase)
            2'h0: begin
              hn.scl_oe = 1'h1;
            end
            2'h1: begin
              // Release for the acknowledge slot and for bus clearing
              hn.sda_oe = !hq.clearing && (hq.bit_idx != ACK_SLOT) && !hq.shift[7];
            end
            2'h2: begin
              hn.scl_oe = 1'h0;
            end
            default: begin
              hn.bit_idx = hq.bit_idx + 4'h1;
              hn.shift   = {hq.shift[6:0], 1'h0};
              if (hq.bit_idx == ACK_SLOT) begin
                hn.bit_idx = 4'h0;
                if (hq.clearing) begin
                  hn.clearing = 1'h0;
                  hn.busy     = 1'h0;
                  hn.st       = H_IDLE;
                end else if (!hq.data_byte && !hq.sda_s2) begin
                  hn.data_byte = 1'h1;
                  hn.shift     = hq.tx_byte;
                end else begin
                  hn.nack_addr = !hq.data_byte && hq.sda_s2;
                  hn.nack_data = hq.data_byte && hq.sda_s2;
                  hn.st        = H_STOP;
                end
              end
            end
          endcase
        end
      end
      default: begin
        // Stop: clock low, data low, clock high, data released high
        if (tick) begin
          hn.phase = hq.phase + 2'h1;
          case (hq.phase)
            2'h0: hn.scl_oe = 1'h1;
            2'h1: hn.sda_oe = 1'h1;
            2'h2: hn.scl_oe = 1'h0;
            default: begin
              hn.sda_oe = 1'h0;
              hn.busy   = 1'h0;
              hn.st     = H_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // After reset nine released clocks flush any half-finished frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hq          <= '0;
      hq.st       <= H_BIT;
      hq.clearing <= 1'h1;
      hq.busy     <= 1'h1;
      hq.sda_s1   <= 1'h1;
      hq.sda_s2   <= 1'h1;
    end else begin
      hq <= hn;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.m_scl_o  = 1'h0;
  assign link.m_scl_oe = hq.scl_oe;
  assign link.m_sda_o  = 1'h0;
  assign link.m_sda_oe = hq.sda_oe;
  assign reg_rdata     = hq.rdata;
  assign busy          = hq.busy;

endmodule

//--- verif/asb_link_sva.sv
// Concurrent checks on the two-wire link joining the host end and the device end
module asb_link_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [7:0] rise_cnt_r;
  logic [7:0] ack_cnt_r;
  logic [7:0] hi_cnt_r;
  logic       in_frame_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic       ack_q_r;
  logic       start_ev;
  logic       stop_ev;

  // Bus conditions: data edge while the clock stays high
  assign start_ev = scl && scl_q_r && sda_q_r && !sda;
  assign stop_ev  = scl && scl_q_r && !sda_q_r && sda;

  // Clock rises counted from START; the count is what frames are judged by
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rise_cnt_r <= 8'h00;
      ack_cnt_r  <= 8'h00;
      hi_cnt_r   <= 8'h00;
      in_frame_r <= 1'b0;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      ack_q_r    <= 1'b0;
    end else begin
      scl_q_r    <= scl;
      sda_q_r    <= sda;
      ack_q_r    <= s_sda_oe;
      rise_cnt_r <= start_ev ? 8'h00 : rise_cnt_r + {7'h00, scl && !scl_q_r};
      ack_cnt_r  <= (s_sda_oe && !ack_q_r) ? 8'h00 : ack_cnt_r + {7'h00, s_sda_oe && scl && !scl_q_r};
      hi_cnt_r   <= !scl ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hFF};
      in_frame_r <= start_ev ? 1'b1 : (stop_ev ? 1'b0 : in_frame_r);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_dev_sda_low_phase;
    $changed(s_sda_oe) |-> !scl;
  endproperty
  a_dev_sda_low_phase: assert property (p_dev_sda_low_phase) else $error("device moved SDA with SCL high");

  property p_sda_stable_high;
    $rose(scl) |-> $stable(sda) [*2];
  endproperty
  a_sda_stable_high: assert property (p_sda_stable_high) else $error("SDA moved early in SCL high");

  property p_frame_bits;
    stop_ev |-> (rise_cnt_r == 8'h13 || rise_cnt_r == 8'h0A);
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame not whole nine-clock bytes");

  property p_ack_slot;
    s_sda_oe && !ack_q_r |-> (rise_cnt_r == 8'h08 || rise_cnt_r == 8'h11);
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack not in ninth slot");

  property p_ack_len;
    !s_sda_oe && ack_q_r |-> ack_cnt_r == 8'h01;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack not one clock long");

  property p_scl_high_width;
    $rose(scl) |-> scl [*3];
  endproperty
  a_scl_high_width: assert property (p_scl_high_width) else $error("SCL high phase too short");

  property p_dev_in_frame;
    s_sda_oe |-> in_frame_r;
  endproperty
  a_dev_in_frame: assert property (p_dev_in_frame) else $error("device drove SDA outside a frame");

  property p_idle_released;
    !in_frame_r && hi_cnt_r > 8'h0B |-> !m_scl_oe && !s_sda_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle bus driven low");

  property p_open_drain;
    !m_scl_o && !m_sda_o && !s_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  // Main scenarios seen on the wire
  c_start: cover property (start_ev);
  c_ack:   cover property (s_sda_oe && !ack_q_r);
  c_stop:  cover property (stop_ev);
endmodule

//--- verif/testbench.sv
// Self-checking bench: host and device ends joined over the two-wire link
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import asb_pkg::*;

  logic       core_clk, reset, reg_wr, reg_rd, busy, shared_input_ref_pin_ref;
  logic       conv_clk_external, polarity_select, input_mode_select, result_bipolar, setup_update;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ain_pos_code, ain_neg_code, result_code;
  logic [2:0] ref_select, ref_m;
  logic [3:0] channel_select;
  logic [7:0] cfg_m, rd_v, n_upd, upd0;
  logic       clk_m, pol_m;
  logic [31:0] seed;
  int         n_fail, checks, i, k;

  // ****************************************************************
  // Ends, link and checker
  // ****************************************************************
  asb_link_if link ();
  // Short quarter keeps the run brief; 2 is the smallest safe value
  asb_host #(.QUARTER_CYC(2)) u_asb_host (.core_clk, .reset, .link(link), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .busy);
  asb_device u_asb_device (.core_clk, .reset, .link(link), .ain_pos_code, .ain_neg_code, .ref_select,
    .shared_input_ref_pin_ref, .conv_clk_external, .polarity_select, .input_mode_select,
    .channel_select, .result_code, .result_bipolar, .setup_update);
  asb_link_sva u_asb_link_sva (.core_clk(core_clk), .reset(reset), .m_scl_o(link.m_scl_o),
    .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));

  // Clock and update-pulse counter
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Only this process writes the pulse count; scenarios take a snapshot of it
  always @(posedge core_clk) begin
    if (reset) n_upd <= 8'h00;
    else if (setup_update === 1'b1) n_upd <= n_upd + 8'h01;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected code: single-ended passes the channel, else signed difference
  function automatic logic [7:0] exp_res(input logic [7:0] p, input logic [7:0] n, input logic sgl,
                                         input logic bip);
    logic signed [9:0] d;
    d = $signed({2'h0, p}) - $signed({2'h0, n});
    if (sgl) return p;
    if (!bip) return (d < 0) ? UNI_ZERO : d[7:0];
    if (d > 10'sd127) return BIP_MAX;
    if (d < -10'sd128) return BIP_MIN;
    return d[7:0];
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_idle();
    int j;
    j = 0;
    while (busy !== 1'b0 && j < 3000) begin
      @(posedge core_clk);
      #1;
      j++;
    end
    chk(busy, 1'b0);
  endtask

  // Drive both inputs, let the one-cycle latency pass, compare the code
  task automatic conv(input logic [7:0] p, input logic [7:0] n);
    @(posedge core_clk);
    ain_pos_code <= p;
    ain_neg_code <= n;
    repeat (2) @(posedge core_clk);
    #1;
    chk(result_code, exp_res(p, n, cfg_m[CFG_MODE_BIT], pol_m));
    chk(result_bipolar, !cfg_m[CFG_MODE_BIT] && pol_m);
  endtask

  // One write transaction; a second write while busy must be dropped
  task automatic send(input logic [7:0] b);
    wait_idle();
    upd0 = n_upd;
    wr(REG_TX, b);
    wr(REG_TX, ~b);
    wait_idle();
    rd(REG_TX, rd_v);
    chk(rd_v, b);
    rd(REG_STATUS, rd_v);
    chk(rd_v, 8'h00);
    chk(n_upd - upd0, 8'h01);
    if (b[SB_KIND_BIT]) begin
      ref_m = b[SB_REF_HI:SB_REF_LO];
      clk_m = b[SB_CLK_BIT];
      pol_m = b[SB_POL_BIT];
      if (!b[SB_CRST_BIT]) cfg_m = CFG_RESET;
    end else begin
      cfg_m = b;
    end
    chk(ref_select, ref_m);
    chk(shared_input_ref_pin_ref, ref_m[SB_SHARE_BIT]);
    chk(conv_clk_external, clk_m);
    chk(polarity_select, pol_m);
    chk(input_mode_select, cfg_m[CFG_MODE_BIT]);
    chk(channel_select, cfg_m[CFG_CS_HI:CFG_CS_LO]);
    conv(8'hFF, 8'h00);
    conv(8'h00, 8'hFF);
    conv(8'h80, 8'h80);
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      conv(seed[7:0], seed[15:8]);
    end
  endtask

  // Watchdog: far beyond the expected run of some 3,000 cycles
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ain_pos_code = 8'h00;
    ain_neg_code = 8'h00;
    n_fail = 0;
    checks = 0;
    seed = 32'd45;
    ref_m = REF_RESET;
    clk_m = CLK_RESET;
    pol_m = POL_RESET;
    cfg_m = CFG_RESET;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h10, rd_v);
    chk(rd_v, 8'h00);
    chk(ref_select, REF_RESET);
    chk(conv_clk_external, CLK_RESET);
    chk(polarity_select, POL_RESET);
    conv(8'h10, 8'h40);
    // Corners: config, setup all ones, setup keeping config, setup resetting config
    send(8'h1E);
    send(8'hFE);
    send(8'hFF);
    conv(8'h20, 8'hE0);
    send(8'hA0);
    send(8'h00);
    send(8'hF5);
    for (i = 0; i < 10; i++) begin
      seed = xs(seed);
      send(seed[7:0]);
    end
    // A write to the status address must neither start a transfer nor land
    wr(REG_STATUS, 8'h5A);
    rd(REG_STATUS, rd_v);
    chk(rd_v, 8'h00);
    stop_test();
  end
endmodule
